// *** gsgc_gate_ctrl.v ***
// Purpose: Gate generation and gated acquisition control on the sample clock
// Assumes: One sample per clk cycle; gate inputs are asynchronous TTL levels
// Notes: Pre-trigger samples are taken by the memory behind recEnable's lookback
`timescale 1ns/1ps
`include "gsgc_map.vh"

// Functional notes
// - Round gate end to channel alignment
// - Stamps mark true gate edges, unaligned
// - Two stamps per gate when enabled
// - Stamps are gate edges, not acquisition
// - Segment length gate plus align, pre, post
// - Standard mode stamps when limit expires
// - Trigger out per segment by default
// - Trigger out whole acquisition when set
// - Inputs count only when masked in
// - Positive edge opens, falling closes
// - High level opens, low closes
// - Rising opens, second rising closes
// - Negative edge opens, rising closes
// - Low level opens, high closes
// - Falling opens, second falling closes
// - Long high pulse opens, falling closes
// - Width in samples, range 2 to 65535
// - Code 4000001h selects long pulse
// - Pre count before, post after gate
// - Standard mode stops at total count
module gsgc_gate_ctrl #(
	parameter TS_W = 32
) (
	input wire clk,
	input wire rst_b,
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [2:0] gateIn,
	output reg trigOut,
	output reg recEnable,
	output reg acqRunning,
	output reg stampValid,
	output reg [1:0] stampKind,
	output reg [TS_W-1:0] stampValue
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_WAIT = 6'h02;
	localparam [5:0] ST_GATE = 6'h04;
	localparam [5:0] ST_ALIGN = 6'h08;
	localparam [5:0] ST_POST = 6'h10;
	localparam [5:0] ST_DONE = 6'h20;

	reg [5:0] state;
	reg [4:0] ctrl;
	reg [31:0] longTrig;
	reg [31:0] orMask;
	reg [31:0] gateMode;
	reg [15:0] pulseWidth;
	reg [31:0] preCount, postCount, totalCount;
	reg [2:0] syncA, syncB;
	reg gatePrev, firstCycle, edgeCount, pwArmed;
	reg [15:0] pwCount;
	reg [TS_W-1:0] timeNow;
	reg [31:0] recCount, postLeft;
	reg gateOdd, startPulse, stopPulse;
	reg [31:0] next_readdata;

	wire busAct = (avs_read | avs_write) & ~avs_waitrequest;
	wire busWr = avs_write & ~avs_waitrequest;
	wire running = (state != ST_IDLE) & (state != ST_DONE);
	wire recording = (state == ST_GATE) | (state == ST_ALIGN) | (state == ST_POST);
	wire stdMode = ctrl[`GSGC_CTL_STDMODE];
	wire stampEn = ctrl[`GSGC_CTL_STAMPEN];

	// ----------------------------------------------------------------
	// Byte lane merge
	// ----------------------------------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] din;
		input [3:0] be;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = be[i] ? din[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction
	wire [31:0] pwMerged = merge({16'h0000, pulseWidth}, avs_writedata, avs_byteenable);

	// ----------------------------------------------------------------
	// Input synchroniser and source selection
	// ----------------------------------------------------------------
	// Second stage is the only reader of the first
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA <= 3'h0;
			syncB <= 3'h0;
		end else begin
			syncA <= gateIn;
			syncB <= syncA;
		end
	end

	// OR of the enabled sources; a masked-out input never reaches the detector
	wire gateSig = (syncB[0] & orMask[`GSGC_MASK_MAIN]) |
		(syncB[1] & orMask[`GSGC_MASK_XIN0]) |
		(syncB[2] & orMask[`GSGC_MASK_XIN1]);

	// First cycle after start sees no edge, so the edge modes ignore a level present at start
	wire rise = gateSig & ~gatePrev & ~firstCycle;
	wire fall = ~gateSig & gatePrev & ~firstCycle;

	// ----------------------------------------------------------------
	// Gate open and close conditions per mode
	// ----------------------------------------------------------------
	reg openCond, closeCond;
	always @* begin
		openCond = 1'b0;
		closeCond = 1'b0;
		case (gateMode)
			`GSGC_MODE_POS: begin
				openCond = rise;
				closeCond = fall;
			end
			`GSGC_MODE_HIGH: begin
				openCond = gateSig;
				closeCond = ~gateSig;
			end
			`GSGC_MODE_POSDBL: begin
				openCond = rise & ~edgeCount;
				closeCond = rise & edgeCount;
			end
			`GSGC_MODE_NEG: begin
				openCond = fall;
				closeCond = rise;
			end
			`GSGC_MODE_LOW: begin
				openCond = ~gateSig;
				closeCond = gateSig;
			end
			`GSGC_MODE_NEGDBL: begin
				openCond = fall & ~edgeCount;
				closeCond = fall & edgeCount;
			end
			`GSGC_MODE_POSPW: begin
				// Width counted in samples; open once the pulse outlasts it
				openCond = pwArmed & gateSig & (pwCount >= pulseWidth);
				closeCond = fall;
			end
			default: openCond = 1'b0;
		endcase
	end

	// Pulse counter restarts on each rising edge after start
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwArmed <= 1'b0;
			pwCount <= 16'h0000;
		end else if (!running || !gateSig) begin
			pwArmed <= 1'b0;
			pwCount <= 16'h0000;
		end else if (rise) begin
			pwArmed <= 1'b1;
			pwCount <= 16'h0001;
		end else if (pwArmed && pwCount != 16'hFFFF) begin
			pwCount <= pwCount + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Register bus: one wait cycle on every access
	// ----------------------------------------------------------------
	always @* begin
		next_readdata = 32'h00000000;
		case (avs_address)
			`GSGC_OFS_CONTROL: next_readdata = {27'h0000000, ctrl};
			`GSGC_OFS_LONGTRIG: next_readdata = longTrig;
			`GSGC_OFS_ORMASK: next_readdata = orMask;
			`GSGC_OFS_GATEMODE: next_readdata = gateMode;
			`GSGC_OFS_PULSEWIDTH: next_readdata = {16'h0000, pulseWidth};
			`GSGC_OFS_PRECOUNT: next_readdata = preCount;
			`GSGC_OFS_POSTCOUNT: next_readdata = postCount;
			`GSGC_OFS_TOTALCOUNT: next_readdata = totalCount;
			`GSGC_OFS_STATUS: next_readdata = {26'h0000000, state};
			`GSGC_OFS_TIMENOW: next_readdata = timeNow[31:0];
			`GSGC_OFS_RECCOUNT: next_readdata = recCount;
			default: next_readdata = 32'h00000000;
		endcase
	end

	// Waitrequest drops for one cycle; the access acts at that edge
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if ((avs_read | avs_write) & avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= avs_read ? next_readdata : 32'h00000000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Configuration writes; start and stop are self-clearing strobes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `GSGC_RST_CONTROL;
			longTrig <= `GSGC_RST_LONGTRIG;
			orMask <= `GSGC_RST_ORMASK;
			gateMode <= `GSGC_RST_GATEMODE;
			pulseWidth <= `GSGC_RST_PULSEWIDTH;
			preCount <= 32'h00000000;
			postCount <= 32'h00000000;
			totalCount <= 32'h00000000;
			startPulse <= 1'b0;
			stopPulse <= 1'b0;
		end else begin
			startPulse <= 1'b0;
			stopPulse <= 1'b0;
			if (busWr) begin
				case (avs_address)
					`GSGC_OFS_CONTROL: begin
						ctrl <= avs_byteenable[0] ? (avs_writedata[4:0] & 5'h1C) : ctrl;
						startPulse <= avs_byteenable[0] & avs_writedata[`GSGC_CTL_START];
						stopPulse <= avs_byteenable[0] & avs_writedata[`GSGC_CTL_STOP];
					end
					`GSGC_OFS_LONGTRIG: longTrig <= merge(longTrig, avs_writedata, avs_byteenable);
					`GSGC_OFS_ORMASK: orMask <= merge(orMask, avs_writedata, avs_byteenable);
					`GSGC_OFS_GATEMODE: gateMode <= merge(gateMode, avs_writedata, avs_byteenable);
					`GSGC_OFS_PULSEWIDTH: pulseWidth <= pwMerged[15:0];
					`GSGC_OFS_PRECOUNT: preCount <= merge(preCount, avs_writedata, avs_byteenable);
					`GSGC_OFS_POSTCOUNT: postCount <= merge(postCount, avs_writedata, avs_byteenable);
					`GSGC_OFS_TOTALCOUNT: totalCount <= merge(totalCount, avs_writedata, avs_byteenable);
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Acquisition sequencer
	// ----------------------------------------------------------------
	// Limit counts every stored sample including the pre-trigger lookback
	wire limitHit = stdMode & recording & (recCount + 32'h00000001 >= totalCount);
	wire oneChan = ctrl[`GSGC_CTL_ONECHAN];
	// Parity before the close edge; an odd gate length needs one more sample with one channel
	wire needAlign = oneChan & ~gateOdd;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			gatePrev <= 1'b0;
			firstCycle <= 1'b1;
			edgeCount <= 1'b0;
			timeNow <= {TS_W{1'b0}};
			recCount <= 32'h00000000;
			postLeft <= 32'h00000000;
			gateOdd <= 1'b0;
			trigOut <= 1'b0;
			recEnable <= 1'b0;
			acqRunning <= 1'b0;
			stampValid <= 1'b0;
			stampKind <= `GSGC_KIND_OPEN;
			stampValue <= {TS_W{1'b0}};
		end else begin
			gatePrev <= gateSig;
			stampValid <= 1'b0;
			firstCycle <= ~running;
			timeNow <= running ? timeNow + {{(TS_W-1){1'b0}}, 1'b1} : timeNow;
			if ((state == ST_WAIT && openCond) || (state == ST_GATE && closeCond)) begin
				edgeCount <= ~edgeCount;
			end
			case (state)
				ST_IDLE, ST_DONE: begin
					recEnable <= 1'b0;
					trigOut <= 1'b0;
					acqRunning <= 1'b0;
					if (startPulse) begin
						state <= ST_WAIT;
						acqRunning <= 1'b1;
						timeNow <= {TS_W{1'b0}};
						recCount <= 32'h00000000;
						edgeCount <= 1'b0;
					end
				end
				ST_WAIT: begin
					if (stopPulse) begin
						state <= ST_DONE;
					end else if (openCond) begin
						state <= ST_GATE;
						recEnable <= 1'b1;
						trigOut <= 1'b1;
						gateOdd <= 1'b0;
						recCount <= recCount + preCount;
						stampValid <= stampEn;
						stampKind <= `GSGC_KIND_OPEN;
						stampValue <= timeNow;
					end
				end
				ST_GATE: begin
					recCount <= recCount + 32'h00000001;
					gateOdd <= ~gateOdd;
					postLeft <= postCount;
					if (stopPulse) begin
						state <= ST_DONE;
					end else if (limitHit) begin
						state <= ST_DONE;
						recEnable <= 1'b0;
						stampValid <= stampEn;
						stampKind <= `GSGC_KIND_LIMIT;
						stampValue <= timeNow;
					end else if (closeCond) begin
						// Stamp is the true close position; the extension follows it
						stampValid <= stampEn;
						stampKind <= `GSGC_KIND_CLOSE;
						stampValue <= timeNow;
						state <= needAlign ? ST_ALIGN : ST_POST;
					end
				end
				ST_ALIGN: begin
					recCount <= recCount + 32'h00000001;
					if (stopPulse || limitHit) begin
						state <= ST_DONE;
						recEnable <= 1'b0;
						stampValid <= stampEn & limitHit & ~stopPulse;
						stampKind <= `GSGC_KIND_LIMIT;
						stampValue <= timeNow;
					end else begin
						state <= ST_POST;
					end
				end
				ST_POST: begin
					recCount <= recCount + 32'h00000001;
					postLeft <= postLeft - 32'h00000001;
					if (stopPulse) begin
						state <= ST_DONE;
					end else if (limitHit) begin
						state <= ST_DONE;
						recEnable <= 1'b0;
						stampValid <= stampEn;
						stampKind <= `GSGC_KIND_LIMIT;
						stampValue <= timeNow;
					end else if (postLeft <= 32'h00000001) begin
						// A zero post count still stores one sample here
						state <= ST_WAIT;
						recEnable <= 1'b0;
						trigOut <= (longTrig[0] == 1'b1);
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// *** gsgc_map.vh ***
// Purpose: Register offsets, field positions, reset values and codes of the gate controller
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes: Shared by the design and its bench, so both read the same codes
`ifndef GSGC_MAP_VH
`define GSGC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GSGC_OFS_CONTROL 6'h00
`define GSGC_OFS_LONGTRIG 6'h04
`define GSGC_OFS_ORMASK 6'h08
`define GSGC_OFS_GATEMODE 6'h0C
`define GSGC_OFS_PULSEWIDTH 6'h10
`define GSGC_OFS_PRECOUNT 6'h14
`define GSGC_OFS_POSTCOUNT 6'h18
`define GSGC_OFS_TOTALCOUNT 6'h1C
`define GSGC_OFS_STATUS 6'h20
`define GSGC_OFS_TIMENOW 6'h24
`define GSGC_OFS_RECCOUNT 6'h28

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define GSGC_CTL_START 0
`define GSGC_CTL_STOP 1
`define GSGC_CTL_STDMODE 2
`define GSGC_CTL_STAMPEN 3
`define GSGC_CTL_ONECHAN 4

// ----------------------------------------------------------------
// Trigger OR mask bits
// ----------------------------------------------------------------
`define GSGC_MASK_MAIN 1
`define GSGC_MASK_XIN0 8
`define GSGC_MASK_XIN1 9

// ----------------------------------------------------------------
// Gate mode codes
// ----------------------------------------------------------------
`define GSGC_MODE_POS 32'h00000001
`define GSGC_MODE_NEG 32'h00000002
`define GSGC_MODE_HIGH 32'h00000008
`define GSGC_MODE_LOW 32'h00000010
`define GSGC_MODE_POSDBL 32'h00800001
`define GSGC_MODE_NEGDBL 32'h08000002
`define GSGC_MODE_POSPW 32'h04000001

// ----------------------------------------------------------------
// Reset values, alignment and stamp kinds
// ----------------------------------------------------------------
`define GSGC_RST_LONGTRIG 32'h00000000
`define GSGC_RST_ORMASK 32'h00000002
`define GSGC_RST_GATEMODE 32'h00000001
`define GSGC_RST_PULSEWIDTH 16'h0002
`define GSGC_RST_CONTROL 5'h04
`define GSGC_ALIGN_ONECHAN 2
`define GSGC_KIND_OPEN 2'h0
`define GSGC_KIND_CLOSE 2'h1
`define GSGC_KIND_LIMIT 2'h2

`endif

// *** gsgc_gate_ctrl_props.sv ***
// Purpose: Port-level assertions for the gate controller
// Assumes: One clock domain, rst_b active low
// Notes: Register contents are not visible here, only bus, gate and stamp ports
`timescale 1ns/1ps
module gsgc_gate_ctrl_props #(
	parameter TS_W = 32
) (
	input wire clk,
	input wire rst_b,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire trigOut,
	input wire recEnable,
	input wire acqRunning,
	input wire stampValid,
	input wire [1:0] stampKind,
	input wire [TS_W-1:0] stampValue
);
	reg [TS_W-1:0] openVal;

	// ----
	// Helper and defaults
	// ----
	// Last open stamp, so a close stamp can be judged against it
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			openVal <= {TS_W{1'b0}};
		else if (stampValid && stampKind == 2'h0)
			openVal <= stampValue;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest stayed low");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	a_stamp_kinds: assert property (stampValid |-> stampKind != 2'h3)
		else $error("unknown stamp kind");
	a_stamp_running: assert property (stampValid && stampKind != 2'h2 |-> acqRunning)
		else $error("gate stamp outside acquisition");
	a_open_at_gate: assert property (stampValid && stampKind == 2'h0 |-> $rose(recEnable))
		else $error("open stamp not at gate start");
	a_close_after_open: assert property (stampValid && stampKind == 2'h1 |-> stampValue > openVal)
		else $error("close stamp not after open stamp");
	a_trig_on_event: assert property ($rose(trigOut) |-> $rose(recEnable))
		else $error("trigger output rose without gate");
	a_rec_in_run: assert property (recEnable |-> acqRunning)
		else $error("recording outside acquisition");
	a_limit_stops: assert property (stampValid && stampKind == 2'h2 |=> !recEnable && !acqRunning)
		else $error("recording went on after limit");
endmodule

bind gsgc_gate_ctrl gsgc_gate_ctrl_props #(.TS_W(TS_W)) i_gsgc_gate_ctrl_props (.clk(clk),
	.rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.trigOut(trigOut), .recEnable(recEnable), .acqRunning(acqRunning), .stampValid(stampValid),
	.stampKind(stampKind), .stampValue(stampValue));

// *** gsgc_gate_src.sv ***
// Purpose: External TTL gate source for the three gate inputs
// Assumes: Levels change just after a rising clock edge
// Notes: TTL lines are always driven, so no released state exists
`timescale 1ns/1ps
module gsgc_gate_src (
	input wire clk,
	output logic [2:0] gateIn
);
	initial gateIn = 3'h0;

	// Hold one input at a level for n sample cycles
	task automatic drive(input int idx, input logic lvl, input int n);
		gateIn[idx] <= lvl;
		repeat (n) @(posedge clk);
	endtask
endmodule

// *** gsgc_gate_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the gate controller
// Assumes: 40 MHz clock, gate source model on the gate inputs
// Notes: Row table covers six gate modes; long pulse and edge cases are written by hand
`timescale 1ns/1ps
`include "gsgc_map.vh"
module gsgc_gate_ctrl_tb_top;
	typedef struct {logic [31:0] mode; logic idle; logic dbl; int len; logic one; int rec;} gsgc_row_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata, stampValue, openV, closeV;
	logic avs_waitrequest, trigOut, recEnable, acqRunning, stampValid;
	logic [1:0] stampKind;
	logic [2:0] gateIn;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int recCnt = 0;
	int stCnt [3] = '{0, 0, 0};
	// Expected recorded samples: gate, one-channel alignment, post count of 3
	gsgc_row_t rows [6] = '{
		'{`GSGC_MODE_POS, 1'b0, 1'b0, 7, 1'b1, 11},
		'{`GSGC_MODE_HIGH, 1'b0, 1'b0, 8, 1'b1, 11},
		'{`GSGC_MODE_POSDBL, 1'b0, 1'b1, 9, 1'b0, 12},
		'{`GSGC_MODE_NEG, 1'b1, 1'b0, 6, 1'b0, 9},
		'{`GSGC_MODE_LOW, 1'b1, 1'b0, 5, 1'b1, 9},
		'{`GSGC_MODE_NEGDBL, 1'b1, 1'b1, 10, 1'b1, 13}};

	gsgc_gate_ctrl i_gsgc_gate_ctrl (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.gateIn(gateIn), .trigOut(trigOut), .recEnable(recEnable), .acqRunning(acqRunning),
		.stampValid(stampValid), .stampKind(stampKind), .stampValue(stampValue));
	gsgc_gate_src i_gsgc_gate_src (.clk(clk), .gateIn(gateIn));

	// ----
	// Clock, tallies and timeout
	// ----
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Scenarios compare tallies before and after, so nothing is cleared here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (recEnable === 1'b1)
			recCnt <= recCnt + 1;
		if (stampValid === 1'b1 && stampKind !== 2'h3) begin
			stCnt[stampKind] <= stCnt[stampKind] + 1;
			if (stampKind == 2'h0)
				openV <= stampValue;
			if (stampKind == 2'h1)
				closeV <= stampValue;
		end
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			stop_test();
		end
	end

	// ----
	// Tasks
	// ----
	task automatic stop_test();
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One Avalon access; held until waitrequest is seen low, only the timeout ends a hang
	task automatic bus(input logic isWr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= isWr;
		avs_read <= !isWr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(q, e);
	endtask
	// Stop first so every scenario starts from a fresh arming
	task automatic arm(input logic [31:0] m, input logic [31:0] c);
		wr(`GSGC_OFS_CONTROL, 32'h2);
		wr(`GSGC_OFS_GATEMODE, m);
		wr(`GSGC_OFS_CONTROL, c);
	endtask
	task automatic pulse(input int i, input int n);
		i_gsgc_gate_src.drive(i, 1'b1, n);
		i_gsgc_gate_src.drive(i, 1'b0, 20);
	endtask
	task automatic runRow(input gsgc_row_t r);
		int rc;
		int cc;
		rc = recCnt;
		cc = stCnt[1];
		// Stop the previous run before the idle level moves, or it opens a stray gate
		wr(`GSGC_OFS_CONTROL, 32'h2);
		i_gsgc_gate_src.drive(0, r.idle, 2);
		arm(r.mode, {27'h0, r.one, 4'h9});
		i_gsgc_gate_src.drive(0, !r.idle, r.dbl ? 2 : r.len);
		if (r.dbl) begin
			i_gsgc_gate_src.drive(0, r.idle, r.len - 2);
			i_gsgc_gate_src.drive(0, !r.idle, 2);
		end
		i_gsgc_gate_src.drive(0, r.idle, 20);
		chk(recCnt - rc, r.rec);
		chk(stCnt[1] - cc, 1);
		chk(closeV - openV, r.len);
		chk({31'h0, trigOut}, 32'h0);
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		int o;
		int c;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rdChk(`GSGC_OFS_CONTROL, 32'h4);
		rdChk(`GSGC_OFS_LONGTRIG, 32'h0);
		rdChk(`GSGC_OFS_ORMASK, 32'h2);
		rdChk(`GSGC_OFS_GATEMODE, 32'h1);
		rdChk(`GSGC_OFS_PULSEWIDTH, 32'h2);
		wr(6'h3C, 32'hFFFFFFFF);
		rdChk(6'h3C, 32'h0);
		wr(`GSGC_OFS_POSTCOUNT, 32'h3);
		foreach (rows[k])
			runRow(rows[k]);
		// High level already present at start: edge mode waits, level mode opens
		i_gsgc_gate_src.drive(0, 1'b1, 2);
		o = stCnt[0];
		arm(`GSGC_MODE_POS, 32'h9);
		i_gsgc_gate_src.drive(0, 1'b1, 20);
		chk(stCnt[0] - o, 0);
		arm(`GSGC_MODE_HIGH, 32'h9);
		pulse(0, 20);
		chk(stCnt[0] - o, 1);
		// Only the masked-in extra input may open a gate
		wr(`GSGC_OFS_ORMASK, 32'h100);
		arm(`GSGC_MODE_POS, 32'h9);
		pulse(0, 6);
		chk(stCnt[0] - o, 1);
		pulse(1, 6);
		chk(stCnt[0] - o, 2);
		wr(`GSGC_OFS_ORMASK, 32'h2);
		// Long pulse: short one refused, long one opens and closes
		wr(`GSGC_OFS_PULSEWIDTH, 32'h5);
		arm(`GSGC_MODE_POSPW, 32'h9);
		c = stCnt[1];
		pulse(0, 3);
		chk(stCnt[0] - o, 2);
		pulse(0, 12);
		chk(stCnt[0] - o, 3);
		chk(stCnt[1] - c, 1);
		// Whole-acquisition trigger output holds until stop
		wr(`GSGC_OFS_LONGTRIG, 32'h1);
		rdChk(`GSGC_OFS_LONGTRIG, 32'h1);
		arm(`GSGC_MODE_POS, 32'h9);
		pulse(0, 5);
		chk({31'h0, trigOut}, 32'h1);
		arm(`GSGC_MODE_POS, 32'h0);
		chk({31'h0, trigOut}, 32'h0);
		wr(`GSGC_OFS_LONGTRIG, 32'h0);
		// Standard mode: total count cuts an open gate short
		wr(`GSGC_OFS_TOTALCOUNT, 32'hA);
		o = recCnt;
		c = stCnt[2];
		arm(`GSGC_MODE_POS, 32'hD);
		pulse(0, 40);
		chk(recCnt - o, 10);
		chk(stCnt[2] - c, 1);
		chk({31'h0, acqRunning}, 32'h0);
		// Reset in mid-gate: outputs drop at once, registers return to reset values
		arm(`GSGC_MODE_HIGH, 32'h9);
		i_gsgc_gate_src.drive(0, 1'b1, 10);
		chk({31'h0, recEnable}, 32'h1);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		chk({27'h0, avs_waitrequest, recEnable, trigOut, acqRunning, stampValid}, 32'h10);
		rst_b <= 1'b1;
		rdChk(`GSGC_OFS_CONTROL, 32'h4);
		rdChk(`GSGC_OFS_GATEMODE, 32'h1);
		stop_test();
	end
endmodule
